// file: verilog/spbs_top.v
// Purpose: Serial port rate selection and mode 0 shift-register engine.
// Assumes: Inputs synchronous to clock; clock is the oscillator.
// Notes:   Registers reached over AXI4-Lite; frame logic of modes 1-3 is outside.
`include "spbs_consts.vh"

module spbs_top (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timer inputs
  input  wire        t1_overflow,
  input  wire        t2_ext_pin,
  input  wire        t2_count_pin,
  // Mode 0 link
  input  wire        serial_data_in,
  output wire        serial_data_out,
  output wire        serial_data_oe,
  output wire        serial_clock_out_line,
  // Bit rate ticks
  output wire        tx_bit_tick,
  output wire        rx_bit_tick
);

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a[7:2] == off[7:2]);
    end
  endfunction

  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = v[7 - k];
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[7:5] == 3'h0);
    end
  endfunction

  // Bus state.
  reg        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg        aw_have_reg, w_have_reg;
  reg [7:0]  awaddr_reg;
  reg [7:0]  wdata_reg;
  reg        wstrb_reg;
  reg [1:0]  bresp_reg, rresp_reg;
  reg [31:0] rdata_reg;
  // Software registers.
  reg [1:0]  mode_reg;
  reg        multiproc_enable_reg, rx_enable_reg, tx_ninth_bit_reg, rx_ninth_bit_reg;
  reg        tx_done_flag_reg, rx_done_flag_reg, double_rate_sel_reg;
  reg        t2_overflow_flag_reg, t2_ext_flag_reg, tx_clk_from_t2_reg, rx_clk_from_t2_reg;
  reg        t2_ext_enable_reg, t2_run_reg, t2_count_select_reg;
  reg [15:0] t2_capture_reg;
  reg [7:0]  serial_buffer_reg, tx_data_reg;
  // Engine state.
  reg        tx_req_reg, tx_wait_reg, send_reg;
  reg [8:0]  tx_sh_reg;
  reg        rx_arm_reg, rx_go_reg, recv_reg, rx_last_reg, rx_samp_reg;
  reg [7:0]  rx_sh_reg;
  reg        ext_prev_reg, cnt_prev_reg, t1_half_reg;
  reg [1:0]  m2_cnt_reg;
  reg        data_out_reg, data_oe_reg, sclk_reg;
  reg [1:0]  bit_tick_reg;

  wire [3:0]  phase;
  wire [15:0] t2_count;
  wire        t2_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the pending bus write.
  wire wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_ok   = wr_fire & wstrb_reg & mapped(awaddr_reg);
  wire wr_sc   = wr_ok & hit(awaddr_reg, `SPBS_OFF_SCTRL);
  wire wr_sb   = wr_ok & hit(awaddr_reg, `SPBS_OFF_SERIAL_BUFFER);
  wire wr_pc   = wr_ok & hit(awaddr_reg, `SPBS_OFF_PWR);
  wire wr_t2   = wr_ok & hit(awaddr_reg, `SPBS_OFF_T2CTRL);
  wire wr_cl   = wr_ok & hit(awaddr_reg, `SPBS_OFF_CAPLO);
  wire wr_ch   = wr_ok & hit(awaddr_reg, `SPBS_OFF_CAPHI);
  wire wr_nl   = wr_ok & hit(awaddr_reg, `SPBS_OFF_CNTLO);
  wire wr_nh   = wr_ok & hit(awaddr_reg, `SPBS_OFF_CNTHI);

  wire baud_mode = tx_clk_from_t2_reg | rx_clk_from_t2_reg;
  wire mode0     = (mode_reg == `SPBS_MODE_SHIFT);
  wire mc_tick   = (phase == `SPBS_PH_S6P2);
  wire st_tick   = phase[0];
  wire ext_fall  = ext_prev_reg & ~t2_ext_pin;
  wire cnt_fall  = cnt_prev_reg & ~t2_count_pin;
  wire tx_fin    = (phase == `SPBS_PH_S1P1) & send_reg & (tx_sh_reg == `SPBS_TX_LASTPAT);
  wire rx_fin    = (phase == `SPBS_PH_S1P1) & rx_last_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.
  spbs_phase_gen u_phase (
    .clock     (clock),
    .rst       (rst),
    .phase_reg (phase)
  );

  spbs_timer2 u_t2 (
    .clock      (clock),
    .rst        (rst),
    .run        (t2_run_reg),
    .baud_mode  (baud_mode),
    .count_sel  (t2_count_select_reg),
    .state_tick (st_tick),
    .mc_tick    (mc_tick),
    .pin_tick   (cnt_fall),
    .reload     (t2_capture_reg),
    .wr_lo      (wr_nl),
    .wr_hi      (wr_nh),
    .wdata      (wdata_reg),
    .count_reg  (t2_count),
    .ovf_reg    (t2_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite channel handshakes.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SPBS_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `SPBS_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid & awready_reg) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid & wready_reg) begin
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb_reg  <= s_axi_wstrb[0];
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(awaddr_reg) ? `SPBS_RESP_OKAY : `SPBS_RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end
      if (bvalid_reg & s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (s_axi_arvalid & arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= mapped(s_axi_araddr) ? `SPBS_RESP_OKAY : `SPBS_RESP_SLVERR;
        rdata_reg   <= 32'h00000000;
        case (s_axi_araddr[4:2])
          3'h0: rdata_reg[7:0] <= {mode_reg, multiproc_enable_reg, rx_enable_reg,
                                   tx_ninth_bit_reg, rx_ninth_bit_reg,
                                   tx_done_flag_reg, rx_done_flag_reg};
          3'h1: rdata_reg[7:0] <= serial_buffer_reg;
          3'h2: rdata_reg[7:0] <= {double_rate_sel_reg, 7'h00};
          3'h3: rdata_reg[7:0] <= {t2_overflow_flag_reg, t2_ext_flag_reg,
                                   rx_clk_from_t2_reg, tx_clk_from_t2_reg,
                                   t2_ext_enable_reg, t2_run_reg, t2_count_select_reg, 1'b0};
          3'h4: rdata_reg[7:0] <= t2_capture_reg[7:0];
          3'h5: rdata_reg[7:0] <= t2_capture_reg[15:8];
          3'h6: rdata_reg[7:0] <= t2_count[7:0];
          default: rdata_reg[7:0] <= t2_count[15:8];
        endcase
        if (!mapped(s_axi_araddr)) begin
          rdata_reg <= 32'h00000000;
        end
      end
      if (rvalid_reg & s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and hardware-set flags (a set wins over a clear).
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg             <= 2'h0;
      multiproc_enable_reg <= 1'b0;
      rx_enable_reg        <= 1'b0;
      tx_ninth_bit_reg     <= 1'b0;
      rx_ninth_bit_reg     <= 1'b0;
      tx_done_flag_reg     <= 1'b0;
      rx_done_flag_reg     <= 1'b0;
      double_rate_sel_reg  <= 1'b0;
      t2_overflow_flag_reg <= 1'b0;
      t2_ext_flag_reg      <= 1'b0;
      tx_clk_from_t2_reg   <= 1'b0;
      rx_clk_from_t2_reg   <= 1'b0;
      t2_ext_enable_reg    <= 1'b0;
      t2_run_reg           <= 1'b0;
      t2_count_select_reg  <= 1'b0;
      t2_capture_reg       <= 16'h0000;
      ext_prev_reg         <= 1'b1;
      cnt_prev_reg         <= 1'b1;
    end else begin
      ext_prev_reg <= t2_ext_pin;
      cnt_prev_reg <= t2_count_pin;
      if (wr_sc) begin
        mode_reg             <= wdata_reg[`SPBS_SC_MODE_HI:`SPBS_SC_MODE_LO];
        multiproc_enable_reg <= wdata_reg[`SPBS_SC_MPROC];
        rx_enable_reg        <= wdata_reg[`SPBS_SC_RXEN];
        tx_ninth_bit_reg     <= wdata_reg[`SPBS_SC_TX9];
        rx_ninth_bit_reg     <= wdata_reg[`SPBS_SC_RX9];
        tx_done_flag_reg     <= wdata_reg[`SPBS_SC_TXDONE];
        rx_done_flag_reg     <= wdata_reg[`SPBS_SC_RXDONE];
      end
      if (tx_fin) begin
        tx_done_flag_reg <= 1'b1;
      end
      if (rx_fin) begin
        rx_done_flag_reg <= 1'b1;
      end
      if (wr_pc) begin
        double_rate_sel_reg <= wdata_reg[`SPBS_PC_DOUBLE];
      end
      if (wr_t2) begin
        t2_overflow_flag_reg <= wdata_reg[`SPBS_T2_OVF];
        t2_ext_flag_reg      <= wdata_reg[`SPBS_T2_EXTF];
        rx_clk_from_t2_reg   <= wdata_reg[`SPBS_T2_RXCLK];
        tx_clk_from_t2_reg   <= wdata_reg[`SPBS_T2_TXCLK];
        t2_ext_enable_reg    <= wdata_reg[`SPBS_T2_EXTEN];
        t2_run_reg           <= wdata_reg[`SPBS_T2_RUN];
        t2_count_select_reg  <= wdata_reg[`SPBS_T2_CSEL];
      end
      if (t2_ovf & ~baud_mode) begin
        t2_overflow_flag_reg <= 1'b1;
      end
      if (ext_fall & t2_ext_enable_reg) begin
        t2_ext_flag_reg <= 1'b1;
      end
      if (wr_cl) begin
        t2_capture_reg[7:0] <= wdata_reg;
      end
      if (wr_ch) begin
        t2_capture_reg[15:8] <= wdata_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0 transmit and receive engine.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_req_reg        <= 1'b0;
      tx_wait_reg       <= 1'b0;
      send_reg          <= 1'b0;
      tx_sh_reg         <= 9'h000;
      tx_data_reg       <= 8'h00;
      rx_arm_reg        <= 1'b0;
      rx_go_reg         <= 1'b0;
      recv_reg          <= 1'b0;
      rx_last_reg       <= 1'b0;
      rx_samp_reg       <= 1'b1;
      rx_sh_reg         <= 8'h00;
      serial_buffer_reg <= 8'h00;
      data_out_reg      <= 1'b1;
      data_oe_reg       <= 1'b0;
      sclk_reg          <= 1'b1;
    end else begin
      if (wr_sb & mode0) begin
        tx_data_reg <= wdata_reg;
        tx_req_reg  <= 1'b1;
      end
      if (mc_tick & tx_req_reg) begin
        tx_sh_reg   <= {1'b1, tx_data_reg};
        tx_req_reg  <= 1'b0;
        tx_wait_reg <= 1'b1;
      end else if (mc_tick & tx_wait_reg) begin
        tx_wait_reg <= 1'b0;
        send_reg    <= 1'b1;
      end else if (mc_tick & send_reg) begin
        tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
      end
      if (tx_fin) begin
        send_reg <= 1'b0;
      end
      if (mode0 & rx_enable_reg & ~rx_done_flag_reg & ~rx_arm_reg & ~rx_go_reg
          & ~recv_reg) begin
        rx_arm_reg <= 1'b1;
      end
      if ((phase == `SPBS_PH_S1P1) & rx_arm_reg) begin
        rx_arm_reg <= 1'b0;
        rx_go_reg  <= 1'b1;
      end
      if (phase == `SPBS_PH_S5P2) begin
        rx_samp_reg <= serial_data_in;
      end
      if (mc_tick & rx_go_reg) begin
        rx_sh_reg <= `SPBS_RX_PRELOAD;
        rx_go_reg <= 1'b0;
        recv_reg  <= 1'b1;
      end else if (mc_tick & recv_reg & ~rx_last_reg) begin
        rx_sh_reg <= {rx_sh_reg[6:0], rx_samp_reg};
        if (!rx_sh_reg[7]) begin
          serial_buffer_reg <= rev8({rx_sh_reg[6:0], rx_samp_reg});
          rx_last_reg       <= 1'b1;
        end
      end
      if (rx_fin) begin
        recv_reg    <= 1'b0;
        rx_last_reg <= 1'b0;
      end
      data_oe_reg  <= send_reg;
      data_out_reg <= send_reg ? tx_sh_reg[0] : 1'b1;
      sclk_reg     <= ~((send_reg | recv_reg)
                        & (phase >= `SPBS_PH_S2P2) & (phase <= `SPBS_PH_S5P1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate sources for the sixteen-times sample tick.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      t1_half_reg <= 1'b0;
      m2_cnt_reg  <= 2'h0;
    end else begin
      m2_cnt_reg <= m2_cnt_reg + 2'h1;
      if (t1_overflow) begin
        t1_half_reg <= ~t1_half_reg;
      end
    end
  end

  wire t1_x16 = t1_overflow & (double_rate_sel_reg | t1_half_reg);
  wire m2_x16 = double_rate_sel_reg ? m2_cnt_reg[0]
                : (m2_cnt_reg == `SPBS_M2_SLOW_DIV - 1);
  wire [1:0] use_t2 = {rx_clk_from_t2_reg, tx_clk_from_t2_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_rate
      reg  [3:0] div_reg;
      wire       x16;
      assign x16 = (mode_reg == `SPBS_MODE_M2) ? m2_x16
                   : (use_t2[gi] ? (t2_ovf & baud_mode) : t1_x16);
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          div_reg          <= 4'h0;
          bit_tick_reg[gi] <= 1'b0;
        end else begin
          if (x16 & ~mode0) begin
            div_reg <= div_reg + 4'h1;
          end
          bit_tick_reg[gi] <= mode0 ? mc_tick
                              : (x16 & (div_reg == `SPBS_X16_DIV - 1));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = wready_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rresp           = rresp_reg;
  assign s_axi_rdata           = rdata_reg;
  assign serial_data_out       = data_out_reg;
  assign serial_data_oe        = data_oe_reg;
  assign serial_clock_out_line = sclk_reg;
  assign tx_bit_tick           = bit_tick_reg[0];
  assign rx_bit_tick           = bit_tick_reg[1];

endmodule

// file: shared/spbs_consts.vh
// Purpose: Constants for the serial port rate and shift-mode block.
// Assumes: One clock, one phase per clock, twelve phases per machine cycle.
// Notes:   Offsets are byte addresses on the register bus.
`ifndef SPBS_CONSTS_VH
`define SPBS_CONSTS_VH

// Register offsets.
`define SPBS_OFF_SCTRL   8'h00
`define SPBS_OFF_SERIAL_BUFFER    8'h04
`define SPBS_OFF_PWR     8'h08
`define SPBS_OFF_T2CTRL  8'h0c
`define SPBS_OFF_CAPLO   8'h10
`define SPBS_OFF_CAPHI   8'h14
`define SPBS_OFF_CNTLO   8'h18
`define SPBS_OFF_CNTHI   8'h1c

// Serial control fields.
`define SPBS_SC_MODE_HI  7
`define SPBS_SC_MODE_LO  6
`define SPBS_SC_MPROC    5
`define SPBS_SC_RXEN     4
`define SPBS_SC_TX9      3
`define SPBS_SC_RX9      2
`define SPBS_SC_TXDONE   1
`define SPBS_SC_RXDONE   0

// Power control field.
`define SPBS_PC_DOUBLE   7

// Second timer control fields.
`define SPBS_T2_OVF      7
`define SPBS_T2_EXTF     6
`define SPBS_T2_RXCLK    5
`define SPBS_T2_TXCLK    4
`define SPBS_T2_EXTEN    3
`define SPBS_T2_RUN      2
`define SPBS_T2_CSEL     1

// Serial modes.
`define SPBS_MODE_SHIFT  2'h0
`define SPBS_MODE_M2     2'h2

// Machine cycle phases (S1P1 is phase 0, S6P2 is phase 11).
`define SPBS_PH_S1P1     4'h0
`define SPBS_PH_S2P2     4'h3
`define SPBS_PH_S5P1     4'h8
`define SPBS_PH_S5P2     4'h9
`define SPBS_PH_S6P2     4'hb
`define SPBS_PHASES      12

// Shift register constants and rate figures.
`define SPBS_RX_PRELOAD  8'hfe
`define SPBS_TX_LASTPAT  9'h001
`define SPBS_M2_SLOW_DIV 4
`define SPBS_X16_DIV     16
`define SPBS_RESP_OKAY   2'h0
`define SPBS_RESP_SLVERR 2'h2

`endif

// file: verilog/spbs_phase_gen.v
// Purpose: Generates the twelve oscillator phases of a machine cycle.
// Assumes: One oscillator period per clock.
// Notes:   Phase 0 is S1P1, phase 11 is S6P2.
`include "spbs_consts.vh"

module spbs_phase_gen (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Phase state
  output reg  [3:0] phase_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter wraps after the last phase.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg <= 4'h0;
    end else if (phase_reg == `SPBS_PHASES - 1) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

endmodule

// file: verilog/spbs_timer2.v
// Purpose: Second timer counter with reload and software write access.
// Assumes: Tick inputs are single-clock pulses.
// Notes:   Overflow pulses for one clock, set on the same edge as the rollover reload.
`include "spbs_consts.vh"

module spbs_timer2 (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Control
  input  wire        run,
  input  wire        baud_mode,
  input  wire        count_sel,
  input  wire        state_tick,
  input  wire        mc_tick,
  input  wire        pin_tick,
  input  wire [15:0] reload,
  // Software writes
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire [7:0]  wdata,
  // State
  output reg  [15:0] count_reg,
  output reg         ovf_reg
);

  wire inc;
  assign inc = run & (count_sel ? pin_tick : (baud_mode ? state_tick : mc_tick));

  ////////////////////////////////////////////////////////////////////////////
  // Counting, rollover reload and writes.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
      ovf_reg   <= 1'b0;
    end else begin
      ovf_reg <= inc & (count_reg == 16'hffff);
      if (wr_lo) begin
        count_reg[7:0] <= wdata;
      end else if (wr_hi) begin
        count_reg[15:8] <= wdata;
      end else if (inc) begin
        if (count_reg == 16'hffff) begin
          count_reg <= reload;
        end else begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

endmodule

// file: test/spbs_checker.sv
// Purpose: Port-level checks of the serial rate and shift block.
// Assumes: One clock; rst is asynchronous and active high.
// Notes:   Attached to the top module by the bind at the foot.
module spbs_checker (
  // Clock and reset
  input logic        clock,
  input logic        rst,
  // Register bus
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Serial side
  input logic        serial_data_out,
  input logic        serial_data_oe,
  input logic        serial_clock_out_line,
  input logic        tx_bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] oe_cnt_reg;
  // Counts the clocks that the data line stays driven.
  always @(posedge clock or posedge rst) begin
    if (rst) oe_cnt_reg <= 8'h00;
    else oe_cnt_reg <= serial_data_oe ? oe_cnt_reg + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////////////////////////
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write overlap");
  a_clk_low_span: assert property ($fell(serial_clock_out_line)
    |-> !serial_clock_out_line [*6] ##1 serial_clock_out_line) else $error("clock low span");
  a_clk_high_span: assert property ($rose(serial_clock_out_line)
    |-> serial_clock_out_line [*6]) else $error("clock high span");
  a_idle_line: assert property (!serial_data_oe |-> serial_data_out)
    else $error("idle line not high");
  a_send_length: assert property ($fell(serial_data_oe) |-> oe_cnt_reg == 8'h61)
    else $error("send length wrong");
  a_send_clock: assert property ($rose(serial_data_oe) |-> serial_clock_out_line)
    else $error("send starts with clock low");
  a_tick_single: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("tick wider than one clock");
  c_send: cover property ($fell(serial_data_oe));
  c_recv: cover property ($fell(serial_clock_out_line) && !serial_data_oe);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind spbs_top spbs_checker chk (.clock, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .serial_data_out, .serial_data_oe, .serial_clock_out_line, .tx_bit_tick);

// file: test/spbs_partner.sv
// Purpose: Shift-register peripheral on the far side of mode 0.
// Assumes: Clock idles high; data is taken on its rising edge.
// Notes:   Drives the line only while the block does not.
module spbs_partner (
  // Link
  input  logic       clock_line,
  input  logic       oe,
  input  logic       line,
  // Control
  input  logic       arm,
  input  logic [7:0] send_byte,
  output logic       drive = 1'b1,
  output logic [7:0] got = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx = 4'h8;
  // Bits arrive and leave least significant first.
  always @(posedge clock_line or posedge arm) begin
    if (arm) idx <= 4'h0;
    else if (oe) got <= {line, got[7:1]};
    else idx <= idx + 4'h1;
  end
  // After the last bit the line keeps changing, not holding stale data.
  always @(negedge clock_line) begin
    if (!oe) drive <= (idx < 4'h8) ? send_byte[idx[2:0]] : ~drive;
  end
endmodule

// file: test/spbs_top_test.sv
// Purpose: Self-checking bench of the serial rate and shift block.
// Assumes: Register bus driven as an AXI4-Lite master.
// Notes:   First timer overflows are modelled as a pulse every 12 clocks.
`include "spbs_consts.vh"
module spbs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bry = 1'b0;
  logic        arv = 1'b0;
  logic        rry = 1'b0;
  logic        t1o = 1'b0;
  logic        t2x = 1'b1;
  logic        arm = 1'b0;
  logic [7:0]  sb = 8'h00;
  logic [3:0]  tc = 4'h0;
  logic [31:0] q;
  logic [1:0]  qr;
  int          errors = 0;
  int          samples_checked = 0;
  wire         awr, wrd, bv, arr, rv, dout, doe, sclk, txt, rxt, drv;
  wire [1:0]   br, rr;
  wire [31:0]  rdat;
  wire [7:0]   got;
  wire         line = doe ? dout : drv;

  spbs_top uut (.clock(clock), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .t1_overflow(t1o),
    .t2_ext_pin(t2x), .t2_count_pin(1'b1), .serial_data_in(line), .serial_data_out(dout),
    .serial_data_oe(doe), .serial_clock_out_line(sclk), .tx_bit_tick(txt),
    .rx_bit_tick(rxt));
  spbs_partner far (.clock_line(sclk), .oe(doe), .line(line), .arm(arm),
    .send_byte(sb), .drive(drv), .got(got));

  initial begin
    forever #4 clock = ~clock;
  end
  // First timer in 8-bit reload with reload value 0xff.
  always @(posedge clock) begin
    tc <= (tc == 4'hb) ? 4'h0 : tc + 4'h1;
    t1o <= (tc == 4'hb);
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clock);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    qr = br;
    bry <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clock);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    q = rdat;
    qr = rr;
    rry <= 1'b0;
  endtask
  task poll(input int b);
    int n;
    n = 0;
    do begin
      rd(`SPBS_OFF_SCTRL);
      n++;
    end while (q[b] !== 1'b1 && n < 100);
  endtask
  task per(input logic sel, input int e);
    int n, k;
    n = 0;
    k = 0;
    while (k < 3 && n < 2000) begin
      @(posedge clock);
      n++;
      if ((sel ? rxt : txt) === 1'b1) k++;
      if ((sel ? rxt : txt) === 1'b1 && k == 2) n = 0;
    end
    chk(n, e);
  endtask
  task rx_once(input logic [7:0] b);
    sb <= b;
    arm <= 1'b1;
    @(posedge clock);
    arm <= 1'b0;
    wr(`SPBS_OFF_SCTRL, 8'h10);
    poll(`SPBS_SC_RXDONE);
    rd(`SPBS_OFF_SERIAL_BUFFER);
  endtask
  ////////////////////////////////////////////////////////////
  task t_shift;
    int k;
    rd(`SPBS_OFF_PWR);
    chk(q, 32'h0);
    wr(`SPBS_OFF_SCTRL, 8'h00);
    per(1'b0, 12);
    wr(`SPBS_OFF_SERIAL_BUFFER, 8'ha5);
    poll(`SPBS_SC_TXDONE);
    chk(q, 32'h02);
    chk(got, 8'ha5);
    rx_once(8'h3c);
    chk(q, 32'h3c);
    k = 0;
    repeat (60) begin
      @(posedge clock);
      if (sclk !== 1'b1) k++;
    end
    chk(k, 0);
    rx_once(8'hc3);
    chk(q, 32'hc3);
    wr(`SPBS_OFF_SCTRL, 8'h00);
  endtask
  task t_rates;
    wr(`SPBS_OFF_SCTRL, 8'h88);
    rd(`SPBS_OFF_SCTRL);
    chk(q, 32'h88);
    per(1'b0, 64);
    wr(`SPBS_OFF_PWR, 8'h80);
    per(1'b0, 32);
    wr(`SPBS_OFF_SCTRL, 8'h40);
    per(1'b0, 192);
    wr(`SPBS_OFF_PWR, 8'h00);
    per(1'b0, 384);
  endtask
  task t_timer2;
    wr(`SPBS_OFF_SCTRL, 8'hc0);
    wr(`SPBS_OFF_CAPLO, 8'hfe);
    wr(`SPBS_OFF_CAPHI, 8'hff);
    wr(`SPBS_OFF_CNTLO, 8'hfe);
    wr(`SPBS_OFF_CNTHI, 8'hff);
    wr(`SPBS_OFF_T2CTRL, 8'h1c);
    per(1'b0, 64);
    per(1'b1, 384);
    t2x <= 1'b0;
    repeat (4) @(posedge clock);
    t2x <= 1'b1;
    rd(`SPBS_OFF_T2CTRL);
    chk(q, 32'h5c);
    per(1'b0, 64);
    wr(`SPBS_OFF_T2CTRL, 8'h24);
    per(1'b1, 64);
    per(1'b0, 384);
    rd(8'h40);
    chk(q, 32'h0);
    chk({30'h0, qr}, 32'h2);
    wr(8'h40, 8'hff);
    chk({30'h0, qr}, 32'h2);
  endtask
  task final_report;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_shift();
    t_rates();
    t_timer2();
    final_report();
  end
  initial begin
    #400us;
    errors++;
    final_report();
  end
endmodule
